//--- design/system_tick_timer.sv
// System tick timer top: AXI4-Lite registers, counter and exception pulse
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "tick_map.svh"
`timescale 1ns/1ps
`default_nettype none

module system_tick_timer #(
    parameter int CNT_W = `TICK_CNT_W
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst_n,

    // AXI4-Lite write address
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [7:0]         s_axi_awaddr,

    // AXI4-Lite write data
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,

    // AXI4-Lite write response
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output tick_pkg::axi_resp_t     s_axi_bresp,

    // AXI4-Lite read address
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [7:0]         s_axi_araddr,

    // AXI4-Lite read data
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic      [31:0]        s_axi_rdata,
    output tick_pkg::axi_resp_t     s_axi_rresp,

    // Core status
    input  wire logic               core_halted,
    input  wire logic               debug_read,

    // Exception request and event interrupt
    output logic                    tick_exc_req,
    output logic                    irq
);
    import tick_pkg::*;

    // ------------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------------
    // Write halves held until both are in
    logic             aw_held_ff;
    logic [7:0]       aw_addr_ff;
    logic             w_held_ff;
    logic [31:0]      w_data_ff;
    logic [3:0]       w_strb_ff;

    // Answers, held until the master takes them
    logic             bvalid_ff;
    axi_resp_t        bresp_ff;
    logic             rvalid_ff;
    logic [31:0]      rdata_ff;
    axi_resp_t        rresp_ff;

    // Readies, registered
    logic             awready_ff;
    logic             wready_ff;
    logic             arready_ff;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    // Software fields
    logic             enable_ff;
    logic             irq_en_ff;
    logic             flag_ff;
    logic [CNT_W-1:0] wrap_ff;
    logic             dbg_kind_ff;

    // Output flops
    logic             exc_ff;
    logic             irq_ff;

    // Word address decode, shared by both paths
    function automatic logic known_addr(input logic [7:0] a);
        return (a == `TICK_CTRL_OFS) || (a == `TICK_WRAP_OFS) ||
               (a == `TICK_COUNT_OFS) || (a == `TICK_EVT_STAT_OFS) ||
               (a == `TICK_EVT_EN_OFS) || (a == `TICK_EVT_CLR_OFS) ||
               (a == `TICK_DBG_OFS);
    endfunction : known_addr

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    // One strobe per write, decoded by address
    wire        wr_go    = aw_held_ff && w_held_ff && !bvalid_ff;
    wire        wr_ctrl  = wr_go && (aw_addr_ff == `TICK_CTRL_OFS);
    wire        wr_wrap  = wr_go && (aw_addr_ff == `TICK_WRAP_OFS);
    wire        wr_count = wr_go && (aw_addr_ff == `TICK_COUNT_OFS);
    wire        wr_en    = wr_go && (aw_addr_ff == `TICK_EVT_EN_OFS);
    wire        wr_clr   = wr_go && (aw_addr_ff == `TICK_EVT_CLR_OFS);
    wire        wr_dbg   = wr_go && (aw_addr_ff == `TICK_DBG_OFS);
    wire        wr_ok    = known_addr(aw_addr_ff);

    // Byte lanes enabled by the write strobes
    wire [31:0] wmask    = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                            {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire [31:0] ctrl_new = w_data_ff & wmask;

    // Capture address and data in either order
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
        end else begin
            // Address half
            if (s_axi_awvalid && awready_ff) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_go) begin
                aw_held_ff <= 1'b0;
            end

            // Data half
            if (s_axi_wvalid && wready_ff) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // Each ready only while its own half is not held and no response waits, so one write at a time
    wire nxt_awready = !aw_held_ff && !(s_axi_awvalid && awready_ff) &&
                       !bvalid_ff;
    wire nxt_wready  = !w_held_ff && !(s_axi_wvalid && wready_ff) &&
                       !bvalid_ff;

    // Write response after both halves
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            awready_ff <= nxt_awready && !wr_go;
            wready_ff  <= nxt_wready && !wr_go;

            // Response stands until bready
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read handshake and address decode
    wire              rd_go    = s_axi_arvalid && arready_ff;
    wire [7:0]        rd_addr  = {s_axi_araddr[7:2], 2'b00};
    wire              rd_ctrl  = rd_go && (rd_addr == `TICK_CTRL_OFS);

    // Counter and event results
    wire [CNT_W-1:0]  cnt_w;
    wire              hit_w;
    wire [1:0]        evt_stat;
    wire [1:0]        evt_en;
    wire              evt_irq;

    // Read data views
    wire [31:0]       ctrl_view;
    logic [31:0]      rd_mux;

    // Control word: flag, clock select fixed at 1, interrupt, enable
    assign ctrl_view = (32'(flag_ff) << `TICK_FLAG_BIT) |
                       (32'h0000_0001 << `TICK_CLK_SEL_BIT) |
                       (32'(irq_en_ff) << `TICK_IRQ_EN_BIT) |
                       (32'(enable_ff) << `TICK_EN_BIT);

    // Read data select; count sampled at the access
    always_comb begin
        case (rd_addr)
            `TICK_CTRL_OFS:     rd_mux = ctrl_view;
            `TICK_WRAP_OFS:     rd_mux = 32'(wrap_ff);
            `TICK_COUNT_OFS:    rd_mux = 32'(cnt_w);
            `TICK_EVT_STAT_OFS: rd_mux = 32'(evt_stat);
            `TICK_EVT_EN_OFS:   rd_mux = 32'(evt_en);
            `TICK_DBG_OFS:      rd_mux = 32'(dbg_kind_ff);
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Read answer; one read at a time
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else begin
            arready_ff <= !rvalid_ff && !rd_go;
            // Data sampled at the handshake
            if (rd_go) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_mux;
                rresp_ff  <= known_addr(rd_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control, wrap value and flag
    // ------------------------------------------------------------------
    // Debugger reads spare the flag when master kind is 1
    wire rd_clears = rd_ctrl && (!debug_read || !dbg_kind_ff);
    wire nxt_flag  = hit_w | (flag_ff & ~rd_clears & ~wr_count);

    // Register writes; the flag updates every cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            enable_ff   <= 1'b0;
            irq_en_ff   <= 1'b0;
            wrap_ff     <= `TICK_WRAP_RST;
            dbg_kind_ff <= 1'b0;
            flag_ff     <= 1'b0;
        end else begin
            if (wr_ctrl && w_strb_ff[0]) begin
                enable_ff <= ctrl_new[`TICK_EN_BIT];
                irq_en_ff <= ctrl_new[`TICK_IRQ_EN_BIT];
            end

            if (wr_wrap) begin
                wrap_ff <= (w_data_ff[CNT_W-1:0] & wmask[CNT_W-1:0]) |
                           (wrap_ff & ~wmask[CNT_W-1:0]);
            end

            if (wr_dbg && w_strb_ff[0]) begin
                dbg_kind_ff <= w_data_ff[`TICK_DBG_KIND_BIT];
            end

            flag_ff <= nxt_flag;
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Halt from the core, clear from a count write
    tick_down_counter #(
        .CNT_W    (CNT_W)
    ) u_counter (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .run      (enable_ff),
        .halted   (core_halted),
        .clear    (wr_count),
        .wrap_val (wrap_ff),
        .count    (cnt_w),
        .hit_zero (hit_w)
    );

    // ------------------------------------------------------------------
    // Events and outputs
    // ------------------------------------------------------------------
    // Bit 0 reached zero, bit 1 pended
    wire [1:0] evt_set = {hit_w && irq_en_ff, hit_w};
    wire [1:0] evt_clr = wr_clr ? w_data_ff[1:0] : 2'b00;

    // Sticky status, enable and level irq
    tick_event_regs #(
        .EVT_W     (`TICK_EVT_W)
    ) u_events (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .evt_set   (evt_set),
        .clr_mask  (evt_clr),
        .en_wr     (wr_en),
        .en_data   (w_data_ff[1:0]),
        .status    (evt_stat),
        .enable    (evt_en),
        .irq_level (evt_irq)
    );

    // Exception pulse registered so the output is a flip-flop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            exc_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            exc_ff <= hit_w && irq_en_ff;
            irq_ff <= evt_irq;
        end
    end

    // Every output straight from a flop
    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // Core side
    assign tick_exc_req  = exc_ff;
    assign irq           = irq_ff;

endmodule : system_tick_timer

`default_nettype wire

//--- design/tick_map.svh
// Register offsets, field positions and reset values of the tick timer
`ifndef TICK_MAP_SVH
`define TICK_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TICK_CTRL_OFS       8'h00
`define TICK_WRAP_OFS       8'h04
`define TICK_COUNT_OFS      8'h08
`define TICK_EVT_STAT_OFS   8'h0C
`define TICK_EVT_EN_OFS     8'h10
`define TICK_EVT_CLR_OFS    8'h14
`define TICK_DBG_OFS        8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TICK_EN_BIT         0
`define TICK_IRQ_EN_BIT     1
`define TICK_CLK_SEL_BIT    2
`define TICK_FLAG_BIT       16
`define TICK_DBG_KIND_BIT   0
`define TICK_DBG_RD_BIT     1

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define TICK_CNT_W          24
`define TICK_CTRL_RST       32'h0000_0004
`define TICK_WRAP_RST       24'h00_0000
`define TICK_EVT_W          2

`endif

//--- design/tick_pkg.sv
// Types shared by the tick timer files
package tick_pkg;

    // Bus response codes
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    // Counter activity
    typedef enum logic [1:0] {
        CNT_IDLE,
        CNT_RUN,
        CNT_HALT
    } cnt_state_t;

endpackage : tick_pkg

//--- design/tick_down_counter.sv
// 24-bit down counter with wrap, clear and debug hold
`timescale 1ns/1ps
`default_nettype none

module tick_down_counter #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             run,
    input  wire logic             halted,
    input  wire logic             clear,
    input  wire logic [CNT_W-1:0] wrap_val,
    // Status
    output logic      [CNT_W-1:0] count,
    output logic                  hit_zero
);
    import tick_pkg::*;

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic             one_w;
    logic             zero_w;
    cnt_state_t       state_w;

    // State view of the counter
    assign state_w = !run ? CNT_IDLE : (halted ? CNT_HALT : CNT_RUN);
    assign one_w   = (count_ff == CNT_W'(1));
    assign zero_w  = (count_ff == '0);

    // Next count: wrap from zero, decrement otherwise
    always_comb begin
        nxt_count = count_ff;
        case (state_w)
            CNT_RUN: begin
                if (zero_w) begin
                    nxt_count = wrap_val;
                end else begin
                    nxt_count = count_ff - CNT_W'(1);
                end
            end
            CNT_HALT: nxt_count = count_ff;
            CNT_IDLE: nxt_count = count_ff;
            default:  nxt_count = count_ff;
        endcase
        if (clear) begin
            nxt_count = '0;
        end
    end

    // Register; a zero wrap value parks at zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Event only on the 1 to 0 step, never from a clear
    assign hit_zero = (state_w == CNT_RUN) && one_w && !clear;
    assign count    = count_ff;

endmodule : tick_down_counter

`default_nettype wire

//--- design/tick_event_regs.sv
// Sticky event status, enable and clear with one level interrupt
`timescale 1ns/1ps
`default_nettype none

module tick_event_regs #(
    parameter int EVT_W = 2
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Events and software access
    input  wire logic [EVT_W-1:0] evt_set,
    input  wire logic [EVT_W-1:0] clr_mask,
    input  wire logic             en_wr,
    input  wire logic [EVT_W-1:0] en_data,
    // State
    output logic      [EVT_W-1:0] status,
    output logic      [EVT_W-1:0] enable,
    output logic                  irq_level
);
    logic [EVT_W-1:0] stat_ff;
    logic [EVT_W-1:0] en_ff;

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_ff <= '0;
            en_ff   <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clr_mask) | evt_set;
            en_ff   <= en_wr ? en_data : en_ff;
        end
    end

    assign status    = stat_ff;
    assign enable    = en_ff;
    assign irq_level = |(stat_ff & en_ff);

endmodule : tick_event_regs

`default_nettype wire

//--- verification/tick_timer_assertions.sv
// Bus and exception checks bound to the tick timer top
`timescale 1ns/1ps
`default_nettype none

module tick_timer_checker
    import tick_pkg::*;
#(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                rst_n,
    // Register bus
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [7:0]          s_axi_araddr,
    input wire logic                s_axi_rvalid,
    input wire logic [31:0]         s_axi_rdata,
    input wire tick_pkg::axi_resp_t s_axi_rresp,
    // Core side
    input wire logic                core_halted,
    input wire logic                tick_exc_req
);
    // ------------------------------------------
    // Address of the read under way
    // ------------------------------------------
    logic [7:0] rd_addr_ff;
    logic [7:0] nxt_rd_addr;
    logic       rd_ctrl;
    logic       rd_count;
    logic       rd_bad;

    // Held so each answer is judged against its own address
    assign nxt_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr
                                                          : rd_addr_ff;
    assign rd_ctrl  = s_axi_rvalid && (rd_addr_ff[7:2] == 6'h00);
    assign rd_count = s_axi_rvalid && (rd_addr_ff[7:2] == 6'h02);
    assign rd_bad   = s_axi_rvalid && (rd_addr_ff[7:2] > 6'h06);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) rd_addr_ff <= 8'h00;
        else rd_addr_ff <= nxt_rd_addr;
    end

    // ------------------------------------------
    // Properties
    // ------------------------------------------
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_exc_one_cycle: assert property (
        tick_exc_req |=> !tick_exc_req)
        else $error("exception request longer than one cycle");
    a_halt_no_exc: assert property (
        core_halted [*4] |=> !tick_exc_req)
        else $error("exception request while core halted");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_write_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
    a_clk_sel_one: assert property (
        rd_ctrl |-> s_axi_rdata[2])
        else $error("clock select not read as one");
    a_count_width: assert property (
        rd_count |-> s_axi_rdata[31:CNT_W] == '0)
        else $error("count upper bits not zero");
    a_unmapped_err: assert property (
        rd_bad |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    // Main scenarios reached
    c_exc_pulse: cover property (tick_exc_req);
    c_unmapped: cover property (rd_bad);
    c_long_halt: cover property (core_halted [*4]);
endmodule : tick_timer_checker

bind system_tick_timer tick_timer_checker #(.CNT_W(CNT_W)) u_chk (
    .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .core_halted, .tick_exc_req
);

`default_nettype wire

//--- verification/system_tick_timer_tb.sv
// Self-checking bench for the system tick timer
`timescale 1ns/1ps
`default_nettype none

module system_tick_timer_tb;
    import tick_pkg::*;

    // ------------------------------------------
    // Signals and tables
    // ------------------------------------------
    logic        ref_clk, rst_n, core_halted, debug_read;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat, v;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, tick_exc_req, irq;
    axi_resp_t   s_axi_bresp, s_axi_rresp, wresp, rresp_v;
    int          errors, cmp_count, cyc, last, gap, pulses, p0;

    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0]  rs;
    } row_t;
    // Address, written, read back, response
    row_t rows [6] = '{
        '{8'h04, 32'hFFFF_FFFF, 32'h00FF_FFFF, 2'h0},
        '{8'h00, 32'hFFFF_FFF8, 32'h0000_0004, 2'h0},
        '{8'h10, 32'h0000_0003, 32'h0000_0003, 2'h0},
        '{8'h18, 32'h0000_0001, 32'h0000_0001, 2'h0},
        '{8'h18, 32'h0000_0000, 32'h0000_0000, 2'h0},
        '{8'h1C, 32'h1234_5678, 32'h0000_0000, 2'h2}
    };

    system_tick_timer #(.CNT_W(24)) DUT (
        .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .core_halted, .debug_read,
        .tick_exc_req, .irq
    );

    // ------------------------------------------
    // Clock, pulse monitor and tasks
    // ------------------------------------------
    always #5 ref_clk = ~ref_clk;

    // Spacing of exception pulses, read before the edge lands
    always @(posedge ref_clk) begin
        cyc++;
        if (tick_exc_req === 1'b1) begin
            gap = cyc - last;
            last = cyc;
            pulses++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        wresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 40) errors++;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        rdat    = s_axi_rdata;
        rresp_v = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) errors++;
    endtask : rd

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Cuts a hung bus short, far beyond the normal run
    initial begin
        #200_000;
        errors++;
        test_done();
    end

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        {ref_clk, rst_n, core_halted, debug_read} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {errors, cmp_count, cyc, last, gap, pulses} = '0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({tick_exc_req, irq}, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i));
            chk(rdat, (i == 0) ? 32'h0000_0004 : 32'h0000_0000);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            chk(wresp, rows[i].rs);
            rd(rows[i].a);
            chk(rdat, rows[i].rd);
            chk(rresp_v, rows[i].rs);
        end
        // Pulse spacing for the smallest wrap, 1, and for the wrap two above it, 3
        for (int w = 1; w <= 3; w += 2) begin
            wr(8'h04, 32'(w));
            wr(8'h00, 32'h0000_0003);
            repeat (16) @(posedge ref_clk);
            chk(gap, w + 1);
            wr(8'h00, 32'h0000_0000);
        end
        // Flag clears on read; raise, mask and clear the interrupt
        rd(8'h00);
        chk(rdat, 32'h0001_0004);
        rd(8'h00);
        chk(rdat, 32'h0000_0004);
        rd(8'h0C);
        chk(rdat, 32'h0000_0003);
        chk(irq, 1'h1);
        wr(8'h10, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'h0);
        wr(8'h10, 32'h0000_0003);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'h1);
        wr(8'h14, 32'h0000_0003);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'h0);
        // Running without interrupt enable: flag only
        wr(8'h00, 32'h0000_0001);
        p0 = pulses;
        repeat (12) @(posedge ref_clk);
        chk(pulses, p0);
        rd(8'h0C);
        chk(rdat, 32'h0000_0001);
        // Halted core freezes the count
        wr(8'h00, 32'h0000_0003);
        core_halted <= 1'b1;
        repeat (2) @(posedge ref_clk);
        p0 = pulses;
        rd(8'h08);
        v = rdat;
        repeat (8) @(posedge ref_clk);
        rd(8'h08);
        chk(rdat, v);
        chk(pulses, p0);
        core_halted <= 1'b0;
        // Zero wrap stops the counter at its next wrap
        wr(8'h04, 32'h0000_0000);
        repeat (8) @(posedge ref_clk);
        p0 = pulses;
        repeat (12) @(posedge ref_clk);
        chk(pulses, p0);
        rd(8'h08);
        chk(rdat, 32'h0000_0000);
        // Live count read near the top of the range
        wr(8'h04, 32'h00FF_FFFF);
        repeat (4) @(posedge ref_clk);
        rd(8'h08);
        v = rdat;
        rd(8'h08);
        chk(rdat < v, 1'h1);
        chk(v[31:8], 32'h0000_FFFF);
        // Count write clears count and flag without pending
        wr(8'h00, 32'h0000_0000);
        wr(8'h14, 32'h0000_0003);
        wr(8'h08, 32'hDEAD_BEEF);
        rd(8'h08);
        chk(rdat, 32'h0000_0000);
        rd(8'h0C);
        chk(rdat & 32'h0000_0002, 32'h0000_0000);
        rd(8'h00);
        chk(rdat, 32'h0000_0004);
        // Debugger reads keep the flag when master kind is one
        wr(8'h04, 32'h0000_0003);
        wr(8'h00, 32'h0000_0001);
        repeat (8) @(posedge ref_clk);
        wr(8'h00, 32'h0000_0000);
        debug_read <= 1'b1;
        wr(8'h18, 32'h0000_0001);
        rd(8'h00);
        rd(8'h00);
        chk(rdat, 32'h0001_0004);
        wr(8'h18, 32'h0000_0000);
        rd(8'h00);
        chk(rdat, 32'h0001_0004);
        rd(8'h00);
        chk(rdat, 32'h0000_0004);
        debug_read <= 1'b0;
        // Mid-run reset: registers and outputs back to reset values
        wr(8'h00, 32'h0000_0003);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({tick_exc_req, irq}, 32'h0000_0000);
        rd(8'h00);
        chk(rdat, 32'h0000_0004);
        rd(8'h04);
        chk(rdat, 32'h0000_0000);
        test_done();
    end
endmodule : system_tick_timer_tb

`default_nettype wire
